// ### hdl/dac_link_pkg.sv
package dac_link_pkg;

  // ***********************************************************
  // Address byte
  // ***********************************************************
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [2:0] LOW_BITS_RESET = 3'h0;

  // ***********************************************************
  // Strap pin sense codes
  // ***********************************************************
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;
  localparam logic [1:0] STRAP_RESET = 2'h0;
  // Cycles after reset release before the straps are latched
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

  // ***********************************************************
  // Bit counting within a nine-clock byte frame
  // ***********************************************************
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;

  // ***********************************************************
  // Access field
  // ***********************************************************
  localparam logic [3:0] ACCESS_LAST_CHANNEL = 4'h7;
  localparam logic [3:0] ACCESS_ALL = 4'hF;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_CMD   = 5'b00100,
    ST_UPPER = 5'b01000,
    ST_LOWER = 5'b10000
  } link_state_t;

endpackage : dac_link_pkg

// ### hdl/bus_events_if.sv
`timescale 1ns/1ns
interface bus_events_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport producer (output scl_rise, output scl_fall, output start,
                    output stop, output sda);
  modport consumer (input scl_rise, input scl_fall, input start,
                    input stop, input sda);
endinterface : bus_events_if

// ### hdl/bus_sampler.sv
`timescale 1ns/1ns
module bus_sampler (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  bus_events_if.producer ev
);

  // ***********************************************************
  // Two-stage synchronisers
  // ***********************************************************
  logic scl_meta_r;
  logic scl_sync_r;
  logic scl_prev_r;
  logic sda_meta_r;
  logic sda_sync_r;
  logic sda_prev_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_i;
      scl_sync_r <= scl_meta_r;
      sda_meta_r <= sda_i;
      sda_sync_r <= sda_meta_r;
    end
  end

  // Idle bus is high, so no false edge appears at reset release
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_sync_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  // ***********************************************************
  // Edge and condition detection
  // ***********************************************************
  assign ev.scl_rise = scl_sync_r & ~scl_prev_r;
  assign ev.scl_fall = ~scl_sync_r & scl_prev_r;
  assign ev.start = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
  assign ev.stop = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;
  assign ev.sda = sda_sync_r;

endmodule : bus_sampler

// ### hdl/i2c_dac_update_slave.sv
`timescale 1ns/1ns
module i2c_dac_update_slave #(
  parameter bit SINGLE_STRAP = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] address_strap_low_i,
  input wire logic [1:0] address_strap_high_i,
  output logic [6:0] own_address_o,
  output logic address_ready_o,
  output logic hs_mode_o,
  output logic update_o,
  output logic [3:0] command_o,
  output logic [3:0] access_o,
  output logic access_valid_o,
  output logic [15:0] data_o
);

  bus_events_if ev ();

  bus_sampler u_sampler (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .scl_i  (scl_i),
    .sda_i  (sda_i),
    .ev     (ev.producer)
  );

  // ***********************************************************
  // Strap sensing
  // ***********************************************************
  logic [1:0] strap_low_meta_r;
  logic [1:0] strap_low_sync_r;
  logic [1:0] strap_high_meta_r;
  logic [1:0] strap_high_sync_r;
  logic [2:0] settle_r;
  logic strap_done_r;
  logic [2:0] low_bits_r;
  logic address_ok_r;
  logic [2:0] low_bits_nxt;
  logic address_ok_nxt;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_low_meta_r <= dac_link_pkg::STRAP_RESET;
      strap_low_sync_r <= dac_link_pkg::STRAP_RESET;
      strap_high_meta_r <= dac_link_pkg::STRAP_RESET;
      strap_high_sync_r <= dac_link_pkg::STRAP_RESET;
    end else begin
      strap_low_meta_r <= address_strap_low_i;
      strap_low_sync_r <= strap_low_meta_r;
      strap_high_meta_r <= address_strap_high_i;
      strap_high_sync_r <= strap_high_meta_r;
    end
  end

  // Illegal straps keep address_ready_o low, so the device stays deaf
  always_comb begin
    low_bits_nxt = dac_link_pkg::LOW_BITS_RESET;
    address_ok_nxt = 1'b1;
    if (SINGLE_STRAP) begin
      case (strap_low_sync_r)
        dac_link_pkg::STRAP_LOW: low_bits_nxt = 3'h0;
        dac_link_pkg::STRAP_HIGH: low_bits_nxt = 3'h2;
        dac_link_pkg::STRAP_FLOAT: low_bits_nxt = 3'h4;
        default: address_ok_nxt = 1'b0;
      endcase
    end else begin
      case ({strap_high_sync_r, strap_low_sync_r})
        {dac_link_pkg::STRAP_LOW, dac_link_pkg::STRAP_LOW}:
          low_bits_nxt = 3'h0;
        {dac_link_pkg::STRAP_LOW, dac_link_pkg::STRAP_HIGH}:
          low_bits_nxt = 3'h1;
        {dac_link_pkg::STRAP_HIGH, dac_link_pkg::STRAP_LOW}:
          low_bits_nxt = 3'h2;
        {dac_link_pkg::STRAP_HIGH, dac_link_pkg::STRAP_HIGH}:
          low_bits_nxt = 3'h3;
        {dac_link_pkg::STRAP_FLOAT, dac_link_pkg::STRAP_LOW}:
          low_bits_nxt = 3'h4;
        {dac_link_pkg::STRAP_FLOAT, dac_link_pkg::STRAP_HIGH}:
          low_bits_nxt = 3'h5;
        {dac_link_pkg::STRAP_LOW, dac_link_pkg::STRAP_FLOAT}:
          low_bits_nxt = 3'h6;
        {dac_link_pkg::STRAP_HIGH, dac_link_pkg::STRAP_FLOAT}:
          low_bits_nxt = 3'h7;
        // Float/float and unknown codes leave the device deaf
        default: address_ok_nxt = 1'b0;
      endcase
    end
  end

  // ***********************************************************
  // Strap latch
  // ***********************************************************
  // Latched once; later strap movement is ignored until reset
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_r <= 3'h0;
      strap_done_r <= 1'b0;
      low_bits_r <= dac_link_pkg::LOW_BITS_RESET;
      address_ok_r <= 1'b0;
    end else if (!strap_done_r) begin
      if (settle_r == dac_link_pkg::STRAP_SETTLE_CYCLES) begin
        strap_done_r <= 1'b1;
        low_bits_r <= low_bits_nxt;
        address_ok_r <= address_ok_nxt;
      end else begin
        settle_r <= settle_r + 3'h1;
      end
    end
  end

  logic [6:0] own_address;
  assign own_address = {dac_link_pkg::ADDR_PREFIX, low_bits_r};
  assign own_address_o = own_address;
  assign address_ready_o = strap_done_r & address_ok_r;

  // ***********************************************************
  // Byte framing
  // ***********************************************************
  dac_link_pkg::link_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic ack_r;
  logic hs_r;
  logic [7:0] command_r;
  logic [7:0] upper_r;
  logic [15:0] data_r;
  logic update_r;

  logic addr_accept;
  logic hs_code;
  logic frame_active;
  logic ack_fall;
  logic done_fall;
  logic bus_cond;

  // ***********************************************************
  // Address decode
  // ***********************************************************
  // Used by both the acknowledge drive and the sequencer, so the two
  // can never disagree about whether the device was addressed
  function automatic logic addr_accepted(input logic [7:0] b,
    input logic [6:0] own,
    input logic ready);
    logic match;
    logic reserved;
    logic master_code;
    match = ready & (b[7:1] == own);
    // General call and ten-bit prefixes never equal a 1001 address;
    // testing them anyway keeps a strap decode slip from acking them
    reserved = (b[7:1] == dac_link_pkg::GENERAL_CALL_ADDR) |
      (b[7:3] == dac_link_pkg::TEN_BIT_PREFIX);
    master_code = (b[7:3] == dac_link_pkg::HS_CODE_PREFIX);
    return match & ~reserved & ~master_code;
  endfunction : addr_accepted

  assign addr_accept = addr_accepted(shift_r, own_address, address_ready_o);
  assign hs_code = (shift_r[7:3] == dac_link_pkg::HS_CODE_PREFIX);
  assign frame_active = (state_r != dac_link_pkg::ST_IDLE);
  assign ack_fall = ev.scl_fall & (bit_cnt_r == dac_link_pkg::BIT_ACK);
  assign done_fall = ev.scl_fall & (bit_cnt_r == dac_link_pkg::BIT_DONE);
  // A start or stop anywhere in a byte throws away the partial byte
  assign bus_cond = ev.start | ev.stop;

  // ***********************************************************
  // Bit counter
  // ***********************************************************
  // Bits sampled on rising clock, so data moving while low is harmless
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_r <= dac_link_pkg::BIT_FIRST;
      shift_r <= dac_link_pkg::BYTE_RESET;
    end else if (bus_cond) begin
      bit_cnt_r <= dac_link_pkg::BIT_FIRST;
    end else if (frame_active) begin
      if (ev.scl_rise && bit_cnt_r < dac_link_pkg::BIT_ACK) begin
        shift_r <= {shift_r[6:0], ev.sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (ev.scl_rise && bit_cnt_r == dac_link_pkg::BIT_ACK) begin
        bit_cnt_r <= dac_link_pkg::BIT_DONE;
      end else if (done_fall) begin
        bit_cnt_r <= dac_link_pkg::BIT_FIRST;
      end
    end
  end

  // ***********************************************************
  // Acknowledge drive
  // ***********************************************************
  // Driven from one falling edge to the next so the whole high phase
  // of the ninth clock is covered
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (bus_cond) begin
      ack_r <= 1'b0;
    end else if (ack_fall) begin
      case (state_r)
        dac_link_pkg::ST_ADDR:
          ack_r <= addr_accept;
        dac_link_pkg::ST_CMD: ack_r <= 1'b1;
        dac_link_pkg::ST_UPPER: ack_r <= 1'b1;
        dac_link_pkg::ST_LOWER: ack_r <= 1'b1;
        default: ack_r <= 1'b0;
      endcase
    end else if (done_fall) begin
      ack_r <= 1'b0;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = ack_r;

  // ***********************************************************
  // Transfer sequencing
  // ***********************************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= dac_link_pkg::ST_IDLE;
    end else if (ev.start) begin
      // Any start, repeated or not, asks for the address byte again
      state_r <= dac_link_pkg::ST_ADDR;
    end else if (ev.stop) begin
      state_r <= dac_link_pkg::ST_IDLE;
    end else if (done_fall) begin
      case (state_r)
        dac_link_pkg::ST_ADDR: begin
          // Read-back is not served: a matched read is acknowledged,
          // then the device stays off the line
          if (addr_accept && !shift_r[0]) begin
            state_r <= dac_link_pkg::ST_CMD;
          end else begin
            state_r <= dac_link_pkg::ST_IDLE;
          end
        end
        dac_link_pkg::ST_CMD: state_r <= dac_link_pkg::ST_UPPER;
        dac_link_pkg::ST_UPPER: state_r <= dac_link_pkg::ST_LOWER;
        dac_link_pkg::ST_LOWER: state_r <= dac_link_pkg::ST_UPPER;
        default: state_r <= dac_link_pkg::ST_IDLE;
      endcase
    end
  end

  // ***********************************************************
  // High-speed mode
  // ***********************************************************
  // The sampler runs far faster than even the high-speed bus clock, so
  // the flag changes no timing here; the register logic may read it
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hs_r <= 1'b0;
    end else if (ev.stop) begin
      hs_r <= 1'b0;
    end else if (done_fall && state_r == dac_link_pkg::ST_ADDR &&
                 hs_code) begin
      hs_r <= 1'b1;
    end
  end

  assign hs_mode_o = hs_r;

  // ***********************************************************
  // Command and data capture
  // ***********************************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      command_r <= dac_link_pkg::BYTE_RESET;
    end else if (done_fall && state_r == dac_link_pkg::ST_CMD) begin
      command_r <= shift_r;
    end
  end

  // A lone upper byte waits here; a start sends the sequencer back to
  // the address and a stop to idle, so it is overwritten before any use
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      upper_r <= dac_link_pkg::BYTE_RESET;
    end else if (done_fall && state_r == dac_link_pkg::ST_UPPER) begin
      upper_r <= shift_r;
    end
  end

  // The pulse trails the bus clock fall by the sampler latency, a few
  // system clocks, well before the next bit can arrive
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      data_r <= dac_link_pkg::DATA_RESET;
      update_r <= 1'b0;
    end else if (done_fall && state_r == dac_link_pkg::ST_LOWER) begin
      data_r <= {upper_r, shift_r};
      update_r <= 1'b1;
    end else begin
      update_r <= 1'b0;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  // Channel codes zero to seven and the all-channel code are legal; the
  // register logic must drop any update that carries another code
  function automatic logic access_legal(input logic [3:0] code);
    logic channel;
    logic every_channel;
    channel = (code <= dac_link_pkg::ACCESS_LAST_CHANNEL);
    every_channel = (code == dac_link_pkg::ACCESS_ALL);
    return channel | every_channel;
  endfunction : access_legal

  assign update_o = update_r;
  assign data_o = data_r;
  assign command_o = command_r[7:4];
  assign access_o = command_r[3:0];
  assign access_valid_o = access_legal(command_r[3:0]);

endmodule : i2c_dac_update_slave

// ### test/i2c_dac_update_slave_checker.sv
`timescale 1ns/1ns
module i2c_dac_update_slave_checker (
  input logic mclk_i,
  input logic rst_i,
  input logic scl_i,
  input logic sda_oe_o,
  input logic [6:0] own_address_o,
  input logic address_ready_o,
  input logic hs_mode_o,
  input logic update_o,
  input logic [3:0] command_o,
  input logic [3:0] access_o,
  input logic [15:0] data_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // *****
  // Link side
  // *****
  // Bound assumes the bench's fixed 80 ns bus clock
  property p_oe_len;
    $rose(sda_oe_o) |-> sda_oe_o [*7] ##[1:4] !sda_oe_o;
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("ack pull not one bus clock long");
  property p_oe_scl;
    $changed(sda_oe_o) |-> !scl_i && !$past(scl_i);
  endproperty
  a_oe_scl: assert property (p_oe_scl)
    else $error("ack pull moved while bus clock high");
  property p_hs;
    $rose(hs_mode_o) |-> !$past(sda_oe_o) ##0 !sda_oe_o [*8];
  endproperty
  a_hs: assert property (p_hs)
    else $error("high-speed code acknowledged");
  property p_addr_hold;
    address_ready_o && $past(address_ready_o) |-> $stable(own_address_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("own address changed after latch");

  // *****
  // Update side
  // *****
  property p_upd_ack;
    update_o |-> !sda_oe_o && $past(sda_oe_o);
  endproperty
  a_upd_ack: assert property (p_upd_ack)
    else $error("update not at end of ack");
  property p_upd_gap;
    update_o |=> !update_o [*8];
  endproperty
  a_upd_gap: assert property (p_upd_gap)
    else $error("updates too close");
  property p_data;
    $changed(data_o) |-> update_o;
  endproperty
  a_data: assert property (p_data)
    else $error("data changed without update");
  property p_cmd;
    $changed({command_o, access_o}) |-> $fell(sda_oe_o);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command changed outside ack end");

  c_update: cover property (update_o);
  c_hs: cover property ($rose(hs_mode_o));
  c_ack: cover property ($rose(sda_oe_o));
endmodule : i2c_dac_update_slave_checker

// ### test/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // Lines idle high; the bus clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // From a low clock this is a repeated start
  task automatic start();
    sda_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 sda_o = 1'b0;
    #20 scl_o = 1'b0;
    #20;
  endtask : start

  task automatic stop();
    sda_o = 1'b0;
    #20 scl_o = 1'b1;
    #20 sda_o = 1'b1;
    #20;
  endtask : stop

  // Data moves only while the clock is low
  task automatic wr(input logic [7:0] b, output logic ack);
    if (scl_o) begin
      scl_o = 1'b0;
      #20;
    end
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      #20 scl_o = 1'b1;
      #40 scl_o = 1'b0;
      #20;
    end
    sda_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 ack = !sda_i;
    #20 scl_o = 1'b0;
    #20;
  endtask : wr
endmodule : i2c_master_model

// ### test/i2c_dac_update_slave_tb.sv
`timescale 1ns/1ns
module i2c_dac_update_slave_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] strap_hi = 2'h1, strap_lo = 2'h0;
  wire scl_w, m_sda, sda_w;
  logic sda_val, sda_oe, ready, hs, upd, acc_ok;
  logic [6:0] own, own1;
  logic [3:0] cmd, acc;
  logic [15:0] data;
  logic [15:0] upd_n = 16'h0000;
  int mismatches = 0, check_count = 0, cycles = 0;

  // Open-drain data wire with pull-up
  assign sda_w = m_sda & !(sda_oe & !sda_val);
  always #5 mclk_i = ~mclk_i;

  i2c_master_model m (.scl_o(scl_w), .sda_o(m_sda), .sda_i(sda_w));
  i2c_dac_update_slave dut (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_w),
    .sda_i(sda_w), .sda_o(sda_val), .sda_oe_o(sda_oe),
    .address_strap_low_i(strap_lo), .address_strap_high_i(strap_hi),
    .own_address_o(own), .address_ready_o(ready), .hs_mode_o(hs),
    .update_o(upd), .command_o(cmd), .access_o(acc),
    .access_valid_o(acc_ok), .data_o(data));
  i2c_dac_update_slave #(.SINGLE_STRAP(1'b1)) dut_single (.mclk_i(mclk_i),
    .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(), .sda_oe_o(),
    .address_strap_low_i(strap_lo), .address_strap_high_i(strap_hi),
    .own_address_o(own1), .address_ready_o(), .hs_mode_o(), .update_o(),
    .command_o(), .access_o(), .access_valid_o(), .data_o());

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (upd) upd_n <= upd_n + 16'h0001;
    if (cycles == 10000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bus traffic starts on falling clock edges, away from sampling
  task automatic do_reset(input logic [1:0] hi, input logic [1:0] lo);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    strap_hi <= hi;
    strap_lo <= lo;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (25) @(negedge mclk_i);
  endtask : do_reset

  task automatic settle();
    repeat (5) @(negedge mclk_i);
  endtask : settle

  task automatic xfer(input logic [7:0] b, input logic exp);
    logic a;
    m.wr(b, a);
    check({15'h0, a}, {15'h0, exp});
  endtask : xfer

  task automatic test_straps();
    logic [35:0] tbl;
    logic [3:0] p;
    tbl = 36'hA62985410;
    for (int i = 0; i < 9; i++) begin
      p = tbl[i*4 +: 4];
      do_reset(p[3:2], p[1:0]);
      check({9'h0, own1}, {9'h0, 4'h9, p[1:0], 1'b0});
      if (i < 8) check({8'h0, ready, own}, {9'h1, 4'h9, i[2:0]});
      else check({15'h0, ready}, 16'h0000);
    end
    do_reset(2'h1, 2'h0);
  endtask : test_straps

  task automatic test_update();
    logic [15:0] n0;
    n0 = upd_n;
    m.start();
    xfer(8'h94, 1'b1);
    xfer(8'h31, 1'b1);
    settle();
    check({8'h00, cmd, acc}, 16'h0031);
    xfer(8'hAB, 1'b1);
    settle();
    check(upd_n, n0);
    xfer(8'hCD, 1'b1);
    settle();
    check(upd_n, n0 + 16'h0001);
    check(data, 16'hABCD);
    xfer(8'h12, 1'b1);
    xfer(8'h34, 1'b1);
    settle();
    check(upd_n, n0 + 16'h0002);
    check(data, 16'h1234);
    xfer(8'h55, 1'b1);
    m.start();
    xfer(8'h94, 1'b1);
    xfer(8'h66, 1'b1);
    m.stop();
    settle();
    check(upd_n, n0 + 16'h0002);
    check({8'h00, cmd, acc}, 16'h0066);
    xfer(8'h94, 1'b0);
    m.stop();
  endtask : test_update

  task automatic test_refuse();
    logic [8:0] t [4];
    logic [15:0] n0;
    t = '{9'h195, 9'h092, 9'h000, 9'h0F0};
    n0 = upd_n;
    foreach (t[i]) begin
      m.start();
      xfer(t[i][7:0], t[i][8]);
      xfer(8'h31, 1'b0);
      m.stop();
    end
    check(upd_n, n0);
  endtask : test_refuse

  task automatic test_access();
    logic [8:0] t [4];
    t = '{9'h170, 9'h10F, 9'h07F, 9'h05C};
    foreach (t[i]) begin
      m.start();
      xfer(8'h94, 1'b1);
      xfer(t[i][8:1], 1'b1);
      m.stop();
      settle();
      check({7'h0, cmd, acc, acc_ok}, {7'h0, t[i]});
    end
  endtask : test_access

  task automatic test_hs();
    m.start();
    xfer(8'h0D, 1'b0);
    settle();
    check({15'h0, hs}, 16'h0001);
    m.start();
    xfer(8'h94, 1'b1);
    check({15'h0, hs}, 16'h0001);
    m.stop();
    settle();
    check({15'h0, hs}, 16'h0000);
  endtask : test_hs

  initial begin
    test_straps();
    test_update();
    test_refuse();
    test_access();
    test_hs();
    complete_run();
  end
endmodule : i2c_dac_update_slave_tb

bind i2c_dac_update_slave i2c_dac_update_slave_checker chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
  .own_address_o(own_address_o), .address_ready_o(address_ready_o),
  .hs_mode_o(hs_mode_o), .update_o(update_o), .command_o(command_o),
  .access_o(access_o), .data_o(data_o));
